/* usr_dev.sv */
// readout device: frame number, identity word and interrupt source word
//
// How it works
// - frame command returns last good frame number
// - frame bytes come low first, then high
// - bus reset leaves frame number undefined
// - frame word eleven bits, upper five zero
// - narrow bus: command, then two byte reads
// - wide bus: low lanes command, one word
// - identity read: code high, version low
// - version byte is bcd encoded
// - host reads all four interrupt bytes
// - endpoint flags at bits 23..8, top zero
// - bit 7 shows live suspend state
// - bit 6 set on short packet end
// - pseudo frame each 1 ms, suspend after three
// - bit 4 set on frame start
// - bit 3 set on dma count zero
// - bit 2 set on awake to suspend
// - bit 1 set on resume
// - bit 0 set on bus reset
// - each endpoint owns its own flag
// - word read clears events; endpoint via status
`timescale 1ns/1ns
module usr_dev import usr_pkg::*; #(
  parameter int          PSEUDO_CNT  = PSEUDO_CYCLES,    // cycles per pseudo frame
  parameter logic [7:0]  IDENT_CODE  = IDENT_CODE_DEF,   // arbitrary part code
  parameter logic [7:0]  SILICON_VER = SILICON_VER_DEF   // arbitrary bcd version
) (
  input  wire logic                 core_clk,        // 20 MHz core clock
  input  wire logic                 nrst,            // async reset, active low
  usr_if.dev                        port,            // host command/data port
  input  wire logic                 sof_valid,       // pulse: frame start received without error
  input  wire logic [FRAME_W-1:0]   sof_frame,       // frame number beside sof_valid
  input  wire logic                 bus_reset_det,   // pulse: bus reset seen
  input  wire logic                 resume_det,      // pulse: resume seen
  input  wire logic                 bus_idle_susp,   // level: bus in suspend condition
  input  wire logic                 short_pkt_eot,   // pulse: short packet ended transfer
  input  wire logic                 dma_eot,         // pulse: dma counter reached zero
  input  wire logic [EP_COUNT-1:0]  ep_event,        // pulses: endpoint activity, bit 0 ctrl out
  input  wire logic [EP_COUNT-1:0]  ep_status_read,  // pulses: endpoint status register read
  output logic                      suspend_entry,   // level: suspended by three missed frames
  output logic [31:0]               irq_word         // live interrupt source word
);

  // ****************************************
  // state
  // ****************************************
  logic [FRAME_W-1:0]  last_frame_number;      // last good frame number
  logic [7:0]          active_cmd;             // command from last command phase
  logic [1:0]          data_idx;               // data phase counter
  logic [31:0]         snap;                   // value held for later phases
  logic [EP_COUNT-1:0] endpoint_flags;         // one sticky flag per endpoint
  logic [6:0]          event_flags;            // sticky bits 6..0 except bit 7 slot
  logic [31:0]         pseudo_cnt;             // cycles since last frame start, pseudo frame or bus reset
  logic [1:0]          missed;                 // consecutive missed frame starts
  logic                susp_prev;              // last live suspend state
  logic [15:0]         rdata;                  // registered read data

  // ****************************************
  // decode
  // ****************************************
  wire         cmd_wr      = port.wr_stb && port.cmd_data_select;
  wire         data_rd     = port.rd_stb && !port.cmd_data_select;
  wire         first_rd    = data_rd && (data_idx == 2'd0);
  // a real frame start in the tick cycle wins, so no pseudo flag stands beside it
  wire         pseudo_tick = (pseudo_cnt == 32'(PSEUDO_CNT - 1)) && !sof_valid;
  wire         missed_out  = (missed == 2'(MISSED_LIMIT));
  // bit 7 is a live level, not sticky; a missed-frame suspend shows there too
  wire         live_susp   = bus_idle_susp || missed_out;
  wire         susp_edge   = live_susp && !susp_prev;
  wire         irq_clear   = first_rd && (active_cmd == CMD_READ_IRQ);
  wire [15:0]  frame_word  = {5'h00, last_frame_number};
  wire [15:0]  ident_word  = {IDENT_CODE, SILICON_VER};

  // interrupt word: top byte reserved zero, endpoints, live status, events
  assign irq_word = {8'h00, endpoint_flags, live_susp, event_flags[6:0]};

  // live value of the selected command, zero for unknown codes
  function automatic logic [31:0] cmd_value(input logic [7:0] c, input logic [15:0] f,
                                            input logic [15:0] id, input logic [31:0] iw);
    unique case (c)
      CMD_READ_FRAME: cmd_value = {16'h0000, f};
      CMD_READ_IDENT: cmd_value = {16'h0000, id};
      CMD_READ_IRQ:   cmd_value = iw;
      default:        cmd_value = 32'h00000000;
    endcase
  endfunction

  // first phase reads the live value, later ones the snapshot
  wire [31:0] cur_val = (data_idx == 2'd0) ? cmd_value(active_cmd, frame_word, ident_word, irq_word) : snap;
  // byte or word selected by the phase counter
  wire [7:0]  sel_byte = cur_val[8*data_idx +: 8];
  wire [15:0] sel_word = cur_val[16*data_idx[0] +: 16];
  wire [15:0] next_rdata = port.bus_wide ? sel_word : {8'h00, sel_byte};

  // read data come from a flop and stand until the next data read
  assign port.dev_data = rdata;

  // ****************************************
  // command and data phases
  // ****************************************
  // a command write restarts the phase counter; data writes are ignored
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      active_cmd <= 8'h00;
      data_idx   <= 2'd0;
      snap       <= 32'h00000000;
      rdata      <= 16'h0000;
    end else begin
      if (cmd_wr) begin
        active_cmd <= port.host_data[7:0];  // high lanes ignored
        data_idx   <= 2'd0;
      end else if (data_rd) begin
        data_idx <= data_idx + 2'd1;  // wraps after four, host must finish
      end
      // only the first read sees the live value, so all phases share one word
      if (first_rd) begin
        snap <= cur_val;  // freeze so a frame start cannot mix bytes
      end
      if (data_rd) begin
        rdata <= next_rdata;
      end
    end
  end

  // ****************************************
  // frame number
  // ****************************************
  // bus reset does not touch the value: it is simply not guaranteed afterwards
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      last_frame_number <= FRAME_RESET[FRAME_W-1:0];
    end else if (sof_valid) begin
      last_frame_number <= sof_frame;
    end
  end

  // ****************************************
  // pseudo frame timer
  // ****************************************
  // counts from each frame start; three misses force the suspended state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pseudo_cnt <= 32'h00000000;
      missed     <= 2'd0;
      susp_prev  <= 1'b0;
    end else begin
      susp_prev <= live_susp;
      if (sof_valid || bus_reset_det) begin
        pseudo_cnt <= 32'h00000000;
        missed     <= 2'd0;
      end else if (pseudo_tick) begin
        pseudo_cnt <= 32'h00000000;
        if (!missed_out) begin
          missed <= missed + 2'd1;
        end
      end else if (!missed_out) begin
        pseudo_cnt <= pseudo_cnt + 32'd1;  // timer stops once suspended
      end
    end
  end

  assign suspend_entry = missed_out;

  // ****************************************
  // event flags
  // ****************************************
  // set wins over the read clear so an event in the reading cycle survives
  logic [6:0] ev_set;  // events this cycle
  always_comb begin
    ev_set = 7'h00;
    ev_set[IRQ_SHORT_EOT] = short_pkt_eot;
    ev_set[IRQ_PSEUDO]    = pseudo_tick && !missed_out;
    ev_set[IRQ_SOF]       = sof_valid;
    ev_set[IRQ_EOT]       = dma_eot;
    ev_set[IRQ_SUSP]      = susp_edge;
    ev_set[IRQ_RESUME]    = resume_det;
    ev_set[IRQ_BUS_RESET] = bus_reset_det;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      event_flags <= IRQ_RESET[6:0];
    end else begin
      event_flags <= (irq_clear ? 7'h00 : event_flags) | ev_set;
    end
  end

  // one flag per endpoint, cleared only by that endpoint's status read
  // new activity in the cycle of its status read wins, so no event is lost
  generate
    for (genvar i = 0; i < EP_COUNT; i++) begin : g_ep
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          endpoint_flags[i] <= 1'b0;
        end else if (ep_event[i]) begin
          endpoint_flags[i] <= 1'b1;
        end else if (ep_status_read[i]) begin
          endpoint_flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // usr_dev

/* usr_pkg.sv */
// shared constants for the status readout command block and its host controller
package usr_pkg;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_READ_FRAME = 8'hb4;  // read last frame number
  localparam logic [7:0] CMD_READ_IDENT = 8'hb5;  // read identity word
  localparam logic [7:0] CMD_READ_IRQ   = 8'hc0;  // read interrupt source word

  // ****************************************
  // identity word (values are arbitrary)
  // ****************************************
  localparam logic [7:0] IDENT_CODE_DEF   = 8'h5a;  // arbitrary part code
  localparam logic [7:0] SILICON_VER_DEF  = 8'h10;  // arbitrary, bcd "1.0"

  // ****************************************
  // field layouts
  // ****************************************
  localparam int FRAME_W        = 11;  // frame number bits 10..0
  localparam int EP_COUNT       = 16;  // ctrl out, ctrl in, endpoints 1..14
  localparam int IRQ_EP_LSB     = 8;   // ctrl out flag position
  localparam int IRQ_BUS_LIVE   = 7;   // live suspend status
  localparam int IRQ_SHORT_EOT  = 6;   // short packet end of transfer
  localparam int IRQ_PSEUDO     = 5;   // pseudo frame start
  localparam int IRQ_SOF        = 4;   // frame start seen
  localparam int IRQ_EOT        = 3;   // dma counter reached zero
  localparam int IRQ_SUSP       = 2;   // awake to suspend change
  localparam int IRQ_RESUME     = 1;   // resume seen
  localparam int IRQ_BUS_RESET  = 0;   // bus reset seen
  localparam logic [15:0] FRAME_RESET = 16'h0000;      // frame number after nrst
  localparam logic [31:0] IRQ_RESET   = 32'h00000000;  // interrupt word after nrst

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS    = 50;       // core_clk period
  localparam int PSEUDO_PERIOD_NS = 1000000;  // 1 ms pseudo frame interval
  localparam int PSEUDO_CYCLES    = PSEUDO_PERIOD_NS / CLK_PERIOD_NS;  // longest time, rounds down
  localparam int MISSED_LIMIT     = 3;        // missed frame starts before suspend

  // ****************************************
  // host controller register offsets
  // ****************************************
  localparam logic [3:0] HREG_CMD    = 4'h0;  // write: command code, starts a transfer
  localparam logic [3:0] HREG_CFG    = 4'h1;  // bit 0: 16-bit bus
  localparam logic [3:0] HREG_STATUS = 4'h2;  // bit 0: busy, bit 1: done
  localparam logic [3:0] HREG_RES_LO = 4'h3;  // result bits 15..0
  localparam logic [3:0] HREG_RES_HI = 4'h4;  // result bits 31..16
endpackage : usr_pkg

/* usr_if.sv */
// parallel command/data port between the host controller and the readout device
`timescale 1ns/1ns
interface usr_if;
  logic        cmd_data_select;  // high: command phase, low: data phase
  logic        wr_stb;           // one-cycle write strobe
  logic        rd_stb;           // one-cycle read strobe
  logic        bus_wide;         // high: 16-bit data phases
  logic [15:0] host_data;        // host to device data
  logic [15:0] dev_data;         // device to host data, valid cycle after rd_stb

  modport dev  (input cmd_data_select, wr_stb, rd_stb, bus_wide, host_data, output dev_data);
  modport host (output cmd_data_select, wr_stb, rd_stb, bus_wide, host_data, input dev_data);
endinterface : usr_if

/* usr_host.sv */
// host controller: issues readout commands and gathers the data phases
`timescale 1ns/1ns
module usr_host import usr_pkg::*; (
  input  wire logic        core_clk,  // 20 MHz core clock
  input  wire logic        nrst,      // async reset, active low
  usr_if.host              port,      // device command/data port
  input  wire logic [3:0]  addr,      // register address
  input  wire logic [31:0] wdata,     // write data
  input  wire logic        wr,        // write strobe
  input  wire logic        rd,        // read strobe
  output logic      [31:0] rdata      // read data, cycle after rd
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {H_IDLE, H_CMD, H_READ, H_WAIT} usr_hstate_t;
  usr_hstate_t state;       // transfer sequencer
  logic [7:0]  cmd;         // command in flight
  logic        wide;        // 16-bit bus configuration
  logic        done;        // sticky: transfer finished
  logic [2:0]  left;        // data phases still to read
  logic [1:0]  pos;         // phase index for assembling the result
  logic [31:0] result;      // assembled value

  // phases needed per command; interrupt word is always read whole
  function automatic logic [2:0] phases(input logic [7:0] c, input logic w);
    if (c == CMD_READ_IRQ) begin
      phases = w ? 3'd2 : 3'd4;
    end else begin
      phases = w ? 3'd1 : 3'd2;
    end
  endfunction

  wire start = wr && (addr == HREG_CMD) && (state == H_IDLE);  // ignored while busy

  // ****************************************
  // port drive
  // ****************************************
  assign port.bus_wide        = wide;
  assign port.cmd_data_select = (state == H_CMD);
  assign port.wr_stb          = (state == H_CMD);
  assign port.rd_stb          = (state == H_READ);
  assign port.host_data       = {8'h00, cmd};

  // ****************************************
  // sequencer
  // ****************************************
  // one read at a time: read strobe, then collect data the next cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state  <= H_IDLE;
      cmd    <= 8'h00;
      left   <= 3'd0;
      pos    <= 2'd0;
      result <= 32'h00000000;
      done   <= 1'b0;
    end else begin
      unique case (state)
        H_IDLE: begin
          if (start) begin
            cmd    <= wdata[7:0];
            left   <= phases(wdata[7:0], wide);
            pos    <= 2'd0;
            result <= 32'h00000000;
            done   <= 1'b0;
            state  <= H_CMD;
          end
        end
        H_CMD:  state <= H_READ;
        H_READ: begin
          left  <= left - 3'd1;
          state <= H_WAIT;
        end
        H_WAIT: begin
          if (wide) begin
            result[16*pos[0] +: 16] <= port.dev_data;
          end else begin
            result[8*pos +: 8] <= port.dev_data[7:0];  // low byte first
          end
          pos <= pos + 2'd1;
          if (left == 3'd0) begin
            done  <= 1'b1;
            state <= H_IDLE;
          end else begin
            state <= H_READ;
          end
        end
      endcase
    end
  end

  // configuration register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wide <= 1'b0;
    end else if (wr && addr == HREG_CFG && state == H_IDLE) begin
      wide <= wdata[0];
    end
  end

  // ****************************************
  // register read
  // ****************************************
  wire [31:0] next_rdata = (addr == HREG_CFG)    ? {31'h0, wide} :
                           (addr == HREG_STATUS) ? {30'h0, done, state != H_IDLE} :
                           (addr == HREG_RES_LO) ? {16'h0000, result[15:0]} :
                           (addr == HREG_RES_HI) ? {16'h0000, result[31:16]} : 32'h00000000;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rd ? next_rdata : 32'h00000000;
    end
  end

endmodule // usr_host

/* usr_chk.sv */
// concurrent checks on the link between the host controller and the readout device
`timescale 1ns/1ns
module usr_chk import usr_pkg::*; (
  input wire logic        core_clk,         // core clock
  input wire logic        nrst,             // async reset, active low
  input wire logic        cmd_data_select,  // command or data phase
  input wire logic        wr_stb,           // command write strobe
  input wire logic        rd_stb,           // data read strobe
  input wire logic        bus_wide,         // 16-bit data phases
  input wire logic [15:0] host_data,        // host to device data
  input wire logic [15:0] dev_data          // device to host data
);
  // ****************************************
  // helper state
  // ****************************************
  logic [7:0] last_cmd;  // command of the transfer in flight
  logic [2:0] rd_cnt;    // data reads taken since that command
  wire  frame_rd = rd_stb && (last_cmd == CMD_READ_FRAME);  // frame data read
  wire  ident_rd = rd_stb && (last_cmd == CMD_READ_IDENT);  // identity data read
  wire  irq_rd   = rd_stb && (last_cmd == CMD_READ_IRQ);    // interrupt data read
  // expected identity lane for this read, narrow bus gives version byte first
  wire  [15:0] ident_exp = bus_wide ? {IDENT_CODE_DEF, SILICON_VER_DEF} :
                           (rd_cnt == 3'h0) ? {8'h00, SILICON_VER_DEF} : {8'h00, IDENT_CODE_DEF};

  // track command and read phase, the count restarts with every command
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      last_cmd <= 8'h00;
      rd_cnt   <= 3'h0;
    end else if (wr_stb) begin
      last_cmd <= host_data[7:0];
      rd_cnt   <= 3'h0;
    end else if (rd_stb) begin
      rd_cnt   <= rd_cnt + 3'h1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ****************************************
  // assertions
  // ****************************************
  property p_wr_in_cmd; wr_stb |-> cmd_data_select; endproperty
  a_wr_in_cmd: assert property (p_wr_in_cmd)
    else $error("write strobe outside command phase");
  property p_rd_in_data; rd_stb |-> !cmd_data_select && !wr_stb; endproperty
  a_rd_in_data: assert property (p_rd_in_data)
    else $error("read strobe outside data phase");
  property p_rd_space; rd_stb |=> !rd_stb; endproperty
  a_rd_space: assert property (p_rd_space)
    else $error("reads not spaced");
  property p_high_lane; wr_stb |-> host_data[15:8] == 8'h00; endproperty
  a_high_lane: assert property (p_high_lane)
    else $error("command high lanes not zero");
  property p_data_holds; !rd_stb |=> $stable(dev_data); endproperty
  a_data_holds: assert property (p_data_holds)
    else $error("device data changed without a read");
  property p_narrow_upper; rd_stb && !bus_wide |=> dev_data[15:8] == 8'h00; endproperty
  a_narrow_upper: assert property (p_narrow_upper)
    else $error("narrow read drives upper lanes");
  property p_frame_resv;
    frame_rd && (bus_wide || rd_cnt == 3'h1) |=>
      ($past(bus_wide) ? dev_data[15:11] : dev_data[7:3]) == 5'h00;
  endproperty
  a_frame_resv: assert property (p_frame_resv)
    else $error("frame reserved bits set");
  property p_ident;
    ident_rd && (rd_cnt == 3'h0 || (!bus_wide && rd_cnt == 3'h1)) |=> dev_data == $past(ident_exp);
  endproperty
  a_ident: assert property (p_ident)
    else $error("identity data wrong");
  property p_bcd; ident_rd && rd_cnt == 3'h0 |=> dev_data[7:4] <= 4'h9 && dev_data[3:0] <= 4'h9; endproperty
  a_bcd: assert property (p_bcd)
    else $error("version byte not bcd");
  property p_irq_top;
    irq_rd && rd_cnt == (bus_wide ? 3'h1 : 3'h3) |=> ($past(bus_wide) ? dev_data[15:8] : dev_data[7:0]) == 8'h00;
  endproperty
  a_irq_top: assert property (p_irq_top)
    else $error("interrupt top byte not zero");

  // ****************************************
  // covers
  // ****************************************
  c_frame: cover property (frame_rd && rd_cnt == 3'h1);
  c_ident: cover property (ident_rd && bus_wide);
  c_irq_full: cover property (irq_rd && rd_cnt == 3'h3);
endmodule // usr_chk

/* tb_top.sv */
// self-checking bench: host controller and readout device joined over the link
`timescale 1ns/1ns
module tb_top import usr_pkg::*;;
  localparam int PCNT = 1000;  // short pseudo frame period keeps the run brief
  logic core_clk, nrst, sof_valid, bus_reset_det, resume_det, bus_idle_susp, short_pkt_eot, dma_eot;
  logic [10:0] sof_frame;           // frame number beside sof_valid
  logic [15:0] ep_event, ep_status_read;  // endpoint pulses
  logic [3:0]  addr;                // host register address
  logic [31:0] wdata, rdata, irq_word, got, exp_irq;  // bus data and model word
  logic        wr, rd, suspend_entry;
  int          fails = 0, checked = 0, seed = 97767, j, k;
  int          ev_bits[5] = '{0, 1, 3, 4, 6};  // event inputs, by flag position
  int          frame_q[$];                     // model: good frame numbers in arrival order

  usr_if link ();
  usr_dev #(.PSEUDO_CNT(PCNT)) i_usr_dev (.core_clk(core_clk), .nrst(nrst), .port(link.dev),
    .sof_valid(sof_valid), .sof_frame(sof_frame), .bus_reset_det(bus_reset_det), .resume_det(resume_det),
    .bus_idle_susp(bus_idle_susp), .short_pkt_eot(short_pkt_eot), .dma_eot(dma_eot), .ep_event(ep_event),
    .ep_status_read(ep_status_read), .suspend_entry(suspend_entry), .irq_word(irq_word));
  usr_host i_usr_host (.core_clk(core_clk), .nrst(nrst), .port(link.host), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  usr_chk i_usr_chk (.core_clk(core_clk), .nrst(nrst), .cmd_data_select(link.cmd_data_select),
    .wr_stb(link.wr_stb), .rd_stb(link.rd_stb), .bus_wide(link.bus_wide), .host_data(link.host_data),
    .dev_data(link.dev_data));

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask
  // read data stand in the cycle after the strobe only
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  // one readout command, result assembled from the two result halves
  task automatic run_cmd(input logic [7:0] code, input logic wide, output logic [31:0] res);
    logic [31:0] st, lo, hi;
    int n;
    reg_wr(HREG_CFG, {31'h0, wide});
    reg_wr(HREG_CMD, {24'h0, code});
    st = 32'h0;
    for (n = 0; n < 100 && st[1:0] !== 2'b10; n++) reg_rd(HREG_STATUS, st);
    if (st[1:0] !== 2'b10) begin
      fails++;  // a hung transfer ends the run
      wrap_up();
    end else begin
      reg_rd(HREG_RES_LO, lo);
      reg_rd(HREG_RES_HI, hi);
      res = {hi[15:0], lo[15:0]};
    end
  endtask
  // one-cycle event pulse, flag lands at the edge that drops it
  task automatic pulse_ev(input int b);
    @(posedge core_clk);
    case (b)
      0: bus_reset_det <= 1'b1;
      1: resume_det <= 1'b1;
      3: dma_eot <= 1'b1;
      4: sof_valid <= 1'b1;
      default: short_pkt_eot <= 1'b1;
    endcase
    @(posedge core_clk);
    {bus_reset_det, resume_det, dma_eot, sof_valid, short_pkt_eot} <= 5'h0;
    #1 exp_irq[b] = 1'b1;
  endtask
  // word read clears event flags, endpoint flags and live bit stay
  task automatic read_irq(input logic wide);
    run_cmd(CMD_READ_IRQ, wide, got);
    check("irq read", got, exp_irq);
    exp_irq[6:0] = 7'h0;
    check("irq after read", irq_word, exp_irq);
  endtask

  // main sequence
  initial begin
    {nrst, sof_valid, bus_reset_det, resume_det, bus_idle_susp, short_pkt_eot, dma_eot, wr, rd} = 9'h0;
    {ep_event, ep_status_read, addr, wdata, sof_frame} = '0;
    exp_irq = IRQ_RESET;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    #1 check("irq reset", irq_word, IRQ_RESET);
    reg_rd(4'hf, got);
    check("unmapped", got, 32'h0);
    for (k = 0; k < 6; k++) begin
      j = $random(seed) & 32'h7ff;
      frame_q.push_back(j);
      @(posedge core_clk) sof_frame <= 11'(j);
      pulse_ev(4);
      check("sof flag", irq_word[4], 1'b1);
      run_cmd(CMD_READ_FRAME, k[0], got);
      check("frame", got, frame_q[$]);
      run_cmd(CMD_READ_IDENT, k[0], got);
      check("ident", got, {16'h0, IDENT_CODE_DEF, SILICON_VER_DEF});
    end
    run_cmd(8'h3c, 1'b0, got);
    check("unknown cmd", got, 32'h0);
    read_irq(1'b1);
    for (k = 0; k < 5; k++) pulse_ev(ev_bits[k]);
    check("events live", irq_word, exp_irq);
    read_irq(1'b0);
    for (k = 0; k < 3; k++) begin
      j = ($random(seed) & 15);
      @(posedge core_clk) ep_event[j] <= 1'b1;
      @(posedge core_clk) ep_event <= '0;
      #1 exp_irq[8 + j] = 1'b1;
      check("endpoint own flag", irq_word, exp_irq);
      read_irq(k[0]);
      @(posedge core_clk) ep_status_read[j] <= 1'b1;
      @(posedge core_clk) ep_status_read <= '0;
      #1 exp_irq[8 + j] = 1'b0;
      check("endpoint cleared", irq_word, exp_irq);
    end
    @(posedge core_clk) bus_idle_susp <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 exp_irq[7] = 1'b1;
    exp_irq[2] = 1'b1;
    check("suspend live", irq_word, exp_irq);
    read_irq(1'b0);
    @(posedge core_clk) bus_idle_susp <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 check("awake live", irq_word[7], 1'b0);
    pulse_ev(4);
    repeat (PCNT + 3) @(posedge core_clk);
    #1 check("pseudo flag", {irq_word[5], suspend_entry}, 2'b10);
    repeat (2 * PCNT) @(posedge core_clk);
    #1 check("missed three", {suspend_entry, irq_word[7]}, 2'b11);
    pulse_ev(0);
    check("bus reset flag", irq_word[0], 1'b1);
    wrap_up();
  end
endmodule // tb_top
